// ===== include/rspc_pkg.sv
package rspc_pkg;
  // Register byte addresses on the Avalon word bus
  localparam logic [7:0] SMC_IDX = 8'h33;
  localparam logic [9:0] SMC_ADDR = 10'h0cc;
  localparam logic [9:0] PRR_ADDR = 10'h0d0;
  localparam logic [9:0] RST_CTL_ADDR = 10'h0d4;
  localparam logic [9:0] RST_STAT_ADDR = 10'h0d8;
  // Sleep mode control fields
  localparam int SLEEP_ARM_BIT = 0;
  localparam int SLEEP_MODE_LSB = 1;
  localparam int SLEEP_MODE_MSB = 3;
  localparam logic [7:0] SMC_RESET = 8'h00;
  localparam logic [7:0] SMC_WMASK = 8'h0f;
  // Power reduction fields
  localparam int TIMER1_GATE_BIT = 3;
  localparam int SPI_GATE_BIT = 2;
  localparam int USART_GATE_BIT = 1;
  localparam int CONV_GATE_BIT = 0;
  localparam logic [7:0] PRR_RESET = 8'h00;
  localparam logic [7:0] PRR_WMASK = 8'h0f;
  // Reset control fields
  localparam int JTAG_RST_BIT = 0;
  localparam int COMPARATOR_BANDGAP_SELECT_BIT = 1;
  localparam int CONV_EN_BIT = 2;
  localparam logic [7:0] RST_CTL_RESET = 8'h00;
  localparam logic [7:0] RST_CTL_WMASK = 8'h07;
  // Sleep mode encodings
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_NOISE_RED = 3'h1;
  localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
  localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STANDBY_WAKE_CYCLES = 6;
  localparam int BOD_MIN_NS = 2000;
  localparam int BOD_MIN_CYCLES = (BOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
endpackage

// ===== rtl/rspc_stretch.sv
`timescale 1ns/10ps
// Holds reset for a fuse-selected count after the raw request falls
module rspc_stretch import rspc_pkg::*; #(
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Request and period
  input wire logic raw_rst_in,
  input wire logic [CNT_W-1:0] period_in,
  output logic stretched_out
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic held;
  } rspc_str_type;
  rspc_str_type st, next_st;

  // Any raw request reloads; counting starts on its falling edge
  always_comb begin
    next_st = st;
    if (raw_rst_in) begin
      next_st.cnt = period_in;
      next_st.held = 1'b1;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - CNT_W'(1);
    end else begin
      next_st.held = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st <= '{'0, 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign stretched_out = st.held;
endmodule

// ===== rtl/rspc_sync.sv
`timescale 1ns/10ps
// Two-stage level synchroniser with constant reset value
module rspc_sync import rspc_pkg::*; #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Level
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } rspc_sync_type;
  rspc_sync_type st, next_st;

  // Only the second stage is visible outside
  always_comb begin
    next_st.meta = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st <= '{RESET_VAL, RESET_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;
endmodule

// ===== rtl/rspc_top.sv
`timescale 1ns/10ps
module rspc_top import rspc_pkg::*; #(
  parameter int CNT_W = 20,
  parameter logic [CNT_W-1:0] TOUT_SHORT = 20'd200,
  parameter logic [CNT_W-1:0] TOUT_LONG = 20'd2600
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [1:0] avs_response_out,
  // Core sleep handshake
  input wire logic sleep_instr_in,
  input wire logic wake_in,
  output logic sleep_req_out,
  output logic [2:0] sleep_mode_out,
  output logic sleeping_out,
  output logic wake_ack_out,
  // Reset sources (pins and analog, asynchronous)
  input wire logic por_low_in,
  input wire logic ext_rst_n_in,
  input wire logic wdt_expire_in,
  input wire logic wdt_enable_in,
  input wire logic bod_low_in,
  // Fuses
  input wire logic [1:0] brownout_level_fuse_in,
  input wire logic [1:0] startup_time_fuse_in,
  input wire logic [3:0] clock_select_fuse_in,
  // Reset and gating outputs
  output logic core_rst_out,
  output logic port_rst_out,
  output logic wdt_rst_pulse_out,
  output logic timer1_clk_en_out,
  output logic spi_clk_en_out,
  output logic usart_clk_en_out,
  output logic conv_clk_en_out,
  output logic comp_mux_allow_out,
  output logic bandgap_en_out
);
  typedef struct packed {
    logic [7:0] smc;
    logic [7:0] power_reduction;
    logic [7:0] rctl;
    logic [31:0] rdata;
    logic wait_n;
    logic [1:0] resp;
    logic sleep_req;
    logic [2:0] mode;
    logic sleeping;
    logic [2:0] wake_cnt;
    logic wake_ack;
    logic wdt_prev;
    logic wdt_pulse;
    logic [15:0] bod_cnt;
    logic bod_rst;
    logic core_rst;
    logic port_rst;
    logic [3:0] gates_n;
    logic comp_allow;
    logic bandgap;
  } rspc_top_type;
  rspc_top_type st, next_st;

  logic por_s, ext_n_s, wdt_exp_s, wdt_en_s, bod_s;
  logic raw_rst, stretched, bod_enabled, access;
  logic [CNT_W-1:0] period;

  // Pin and analog inputs cross into the clock domain first
  rspc_sync #(.RESET_VAL(1'b1)) u_sync_por (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .async_in(por_low_in), .sync_out(por_s));
  rspc_sync #(.RESET_VAL(1'b1)) u_sync_ext (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .async_in(ext_rst_n_in), .sync_out(ext_n_s));
  rspc_sync #(.RESET_VAL(1'b0)) u_sync_wexp (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .async_in(wdt_expire_in), .sync_out(wdt_exp_s));
  rspc_sync #(.RESET_VAL(1'b0)) u_sync_wen (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .async_in(wdt_enable_in), .sync_out(wdt_en_s));
  rspc_sync #(.RESET_VAL(1'b0)) u_sync_bod (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .async_in(bod_low_in), .sync_out(bod_s));

  // Fuse 11 means detector disabled; the time fuse picks the stretch
  assign bod_enabled = (brownout_level_fuse_in != 2'h3);
  assign period = (startup_time_fuse_in == 2'h0) ? TOUT_SHORT : TOUT_LONG;

  // Merge of all five sources
  assign raw_rst = por_s | ~ext_n_s | st.wdt_pulse | st.bod_rst
    | st.rctl[JTAG_RST_BIT];

  rspc_stretch #(.CNT_W(CNT_W)) u_stretch (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .raw_rst_in(raw_rst), .period_in(period),
    .stretched_out(stretched));

  // One bus answer per request; waitrequest drops for a single cycle
  assign access = (avs_read_in | avs_write_in) & ~st.wait_n;

  always_comb begin
    next_st = st;
    next_st.wait_n = access;
    next_st.sleep_req = 1'b0;
    next_st.wake_ack = 1'b0;
    // Bus write lands on the edge where waitrequest is seen low, lane 0 only
    if (avs_write_in && st.wait_n && avs_byteenable_in[0]) begin
      unique case (avs_address_in)
        SMC_ADDR: next_st.smc = avs_writedata_in[7:0] & SMC_WMASK;
        PRR_ADDR: next_st.power_reduction = avs_writedata_in[7:0] & PRR_WMASK;
        RST_CTL_ADDR: next_st.rctl = avs_writedata_in[7:0] & RST_CTL_WMASK;
        default: ;
      endcase
    end
    // Read mux; unmapped addresses answer zero with a decode error
    next_st.resp = 2'h0;
    if (access) begin
      unique case (avs_address_in)
        SMC_ADDR: next_st.rdata = {24'h0, st.smc};
        PRR_ADDR: next_st.rdata = {24'h0, 4'h0, st.power_reduction[3:0]};
        RST_CTL_ADDR: next_st.rdata = {24'h0, st.rctl};
        RST_STAT_ADDR: next_st.rdata = {24'h0, 3'h0, st.sleeping, st.bod_rst,
          ~ext_n_s, por_s, stretched};
        default: begin
          next_st.rdata = 32'h0;
          next_st.resp = 2'h3;
        end
      endcase
    end
    // Armed sleep instruction yields one pulse with the sampled mode
    if (sleep_instr_in && st.smc[SLEEP_ARM_BIT] && !st.sleeping) begin
      next_st.sleep_req = 1'b1;
      next_st.mode = st.smc[SLEEP_MODE_MSB:SLEEP_MODE_LSB];
      next_st.sleeping = 1'b1;
      next_st.wake_cnt = 3'h0;
    end
    // Standby keeps the oscillator, so wake takes a fixed short count
    if (st.sleeping && (wake_in || st.wake_cnt != 3'h0)) begin
      if (st.mode != MODE_STANDBY || st.wake_cnt == 3'(STANDBY_WAKE_CYCLES - 1)) begin
        next_st.sleeping = 1'b0;
        next_st.wake_ack = 1'b1;
        next_st.wake_cnt = 3'h0;
      end else begin
        next_st.wake_cnt = st.wake_cnt + 3'h1;
      end
    end
    // Watchdog pulse lasts one cycle on rising expiry when enabled
    next_st.wdt_prev = wdt_exp_s;
    next_st.wdt_pulse = wdt_exp_s & ~st.wdt_prev & wdt_en_s;
    // Brown-out filter: must persist past the minimum duration
    if (bod_enabled && bod_s) begin
      if (st.bod_cnt == 16'(BOD_MIN_CYCLES)) begin
        next_st.bod_rst = 1'b1;
      end else begin
        next_st.bod_cnt = st.bod_cnt + 16'h1;
      end
    end else begin
      next_st.bod_cnt = 16'h0;
      next_st.bod_rst = 1'b0;
    end
    // Registered release keeps every consumer on the same edge
    next_st.core_rst = stretched | raw_rst;
    next_st.port_rst = raw_rst;
    // Gates only stop the clock, so frozen state survives ungating
    next_st.gates_n = ~st.power_reduction[3:0];
    next_st.comp_allow = ~st.power_reduction[CONV_GATE_BIT];
    next_st.bandgap = bod_enabled | st.rctl[COMPARATOR_BANDGAP_SELECT_BIT] | st.rctl[CONV_EN_BIT];
    // Internal reset returns every register except the JTAG bit to its initial value
    if (stretched) begin
      next_st.smc = SMC_RESET;
      next_st.power_reduction = PRR_RESET;
      next_st.rctl = st.rctl & (8'h1 << JTAG_RST_BIT); // JTAG bit survives to hold reset
      next_st.sleeping = 1'b0;
      next_st.sleep_req = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st <= '0;
      st.core_rst <= 1'b1;
      st.port_rst <= 1'b1;
      st.gates_n <= 4'hf;
      st.comp_allow <= 1'b1;
      st.bod_cnt <= 16'h0;
    end else begin
      st <= next_st;
    end
  end

  // Port reset comes only from its registered copy of the raw merge, so it needs the clock to act
  assign port_rst_out = st.port_rst;
  assign core_rst_out = st.core_rst;
  assign wdt_rst_pulse_out = st.wdt_pulse;
  assign avs_readdata_out = st.rdata;
  assign avs_waitrequest_out = ~st.wait_n;
  assign avs_response_out = st.resp;
  assign sleep_req_out = st.sleep_req;
  assign sleep_mode_out = st.mode;
  assign sleeping_out = st.sleeping;
  assign wake_ack_out = st.wake_ack;
  assign timer1_clk_en_out = st.gates_n[TIMER1_GATE_BIT];
  assign spi_clk_en_out = st.gates_n[SPI_GATE_BIT];
  assign usart_clk_en_out = st.gates_n[USART_GATE_BIT];
  assign conv_clk_en_out = st.gates_n[CONV_GATE_BIT];
  assign comp_mux_allow_out = st.comp_allow;
  assign bandgap_en_out = st.bandgap;
endmodule

// ===== sim/rspc_periph_model.sv
`timescale 1ns/10ps
// Stand-in for a gated peripheral: a free counter as its visible state
module rspc_periph_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Gate and state
  input wire logic clk_en_in,
  output logic [7:0] count_out
);
  // State is held, not cleared, while gated so ungating resumes it
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      count_out <= 8'h00;
    end else if (clk_en_in) begin
      count_out <= count_out + 8'h01;
    end
  end
endmodule

// ===== sim/rspc_top_properties.sv
`timescale 1ns/10ps
module rspc_top_properties import rspc_pkg::*; #(
  parameter int CNT_W = 20,
  parameter logic [CNT_W-1:0] TOUT_SHORT = 20'd200,
  parameter logic [CNT_W-1:0] TOUT_LONG = 20'd2600
) (
  // Watched ports
  input wire logic core_clk_in, sys_rst_in, avs_read_in, avs_write_in, avs_waitrequest_out,
  input wire logic sleep_instr_in, sleep_req_out, sleeping_out, ext_rst_n_in, por_low_in,
  input wire logic wdt_enable_in, wdt_rst_pulse_out, port_rst_out, core_rst_out,
  input wire logic conv_clk_en_out, comp_mux_allow_out, bandgap_en_out,
  input wire logic [1:0] brownout_level_fuse_in, startup_time_fuse_in
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Sync stages plus output flop: five cycles covers the latency
  sequence s_pin_held; !ext_rst_n_in [*5]; endsequence
  sequence s_req_once; sleeping_out ##1 !sleep_req_out; endsequence
  AST_BUS_ONE: assert property ($rose(avs_read_in || avs_write_in) |=>
    !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("bus answer not one cycle");
  AST_SLEEP_CAUSE: assert property (sleep_req_out |-> $past(sleep_instr_in))
    else $error("sleep request without instruction");
  AST_SLEEP_PULSE: assert property (sleep_req_out |-> s_req_once)
    else $error("sleep request not one cycle");
  AST_GATE_MUX: assert property (!conv_clk_en_out |-> !comp_mux_allow_out)
    else $error("comparator mux allowed while converter gated");
  AST_BANDGAP_FUSE: assert property ((brownout_level_fuse_in != 2'h3 && !core_rst_out) [*2]
    |-> bandgap_en_out) else $error("bandgap off with detector fused on");
  AST_PIN_RESET: assert property (s_pin_held |-> port_rst_out && core_rst_out)
    else $error("pin reset not asserted");
  AST_POR_RESET: assert property (por_low_in [*5] |-> port_rst_out)
    else $error("power-on reset not asserted");
  AST_STRETCH: assert property ($fell(port_rst_out) && startup_time_fuse_in == 2'h0
    |-> core_rst_out [*8]) else $error("reset released before time-out");
  AST_WDT_PULSE: assert property (wdt_rst_pulse_out |=> !wdt_rst_pulse_out)
    else $error("watchdog pulse longer than one cycle");
  AST_WDT_ENABLE: assert property (!wdt_enable_in [*6] |-> !wdt_rst_pulse_out)
    else $error("watchdog reset while disabled");
endmodule
bind rspc_top rspc_top_properties #(.CNT_W(CNT_W), .TOUT_SHORT(TOUT_SHORT),
  .TOUT_LONG(TOUT_LONG)) i_props (.*);

// ===== sim/test_reset_sleep_power_control.sv
`timescale 1ns/10ps
module test_reset_sleep_power_control import rspc_pkg::*;;
  // Short time-outs keep the run brief
  localparam logic [19:0] TS = 20'd8;
  logic core_clk_in = 1'b0, sys_rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [9:0] avs_address_in = 10'h000;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rdata;
  logic [3:0] avs_byteenable_in = 4'h1, clock_select_fuse_in = 4'h0;
  logic [1:0] avs_response_out, resp, brownout_level_fuse_in = 2'h3, startup_time_fuse_in = 2'h0;
  logic avs_waitrequest_out, sleep_instr_in = 1'b0, wake_in = 1'b0, sleep_req_out, sleeping_out;
  logic wake_ack_out, por_low_in = 1'b0, ext_rst_n_in = 1'b1, wdt_expire_in = 1'b0;
  logic wdt_enable_in = 1'b0, bod_low_in = 1'b0, core_rst_out, port_rst_out, wdt_rst_pulse_out;
  logic timer1_clk_en_out, spi_clk_en_out, usart_clk_en_out, conv_clk_en_out;
  logic comp_mux_allow_out, bandgap_en_out;
  logic [2:0] sleep_mode_out;
  logic [7:0] tcount, c0;
  logic [2:0] modes [5] = '{MODE_IDLE, MODE_NOISE_RED, MODE_POWER_DOWN, MODE_POWER_SAVE,
    MODE_STANDBY};
  int errors = 0, comparisons = 0, n, hi, tout;
  rspc_top #(.CNT_W(20), .TOUT_SHORT(TS), .TOUT_LONG(20'd20)) i_dut (.*);
  rspc_periph_model i_timer1 (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(timer1_clk_en_out), .count_out(tcount));
  // 40 MHz clock
  always #12.5 core_clk_in = !core_clk_in;
  task automatic complete_run();
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 50);
    rdata = avs_readdata_out;
    resp = avs_response_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (k >= 50) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    cmp("readdata", e, rdata);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return port_rst_out;
      1: return core_rst_out;
      2: return sleep_req_out;
      3: return wake_ack_out;
      default: return wdt_rst_pulse_out;
    endcase
  endfunction
  // Bounded wait; cycles taken land in n
  task automatic wait_for(input int s, input logic v);
    n = 0;
    do begin
      @(posedge core_clk_in);
      #1;
      n++;
    end while (pick(s) !== v && n < 400);
    if (n >= 400) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic watch(input int s, input int len);
    hi = 0;
    repeat (len) begin
      @(posedge core_clk_in);
      #1;
      hi += int'(pick(s) === 1'b1);
    end
  endtask
  // Raises the instruction only; the caller lowers it after looking
  task automatic pulse_sleep();
    @(posedge core_clk_in);
    sleep_instr_in <= 1'b1;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    wait_for(1, 1'b0);
    rd(SMC_ADDR, 32'h0);
    rd(PRR_ADDR, 32'h0);
    rd(10'h3fc, 32'h0);
    cmp("response", 32'h3, {30'h0, resp});
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, PRR_ADDR, 8'h01 << i);
      repeat (2) @(posedge core_clk_in);
      #1;
      cmp("enables", {28'h0, ~(4'h1 << i)}, {28'h0, timer1_clk_en_out, spi_clk_en_out,
        usart_clk_en_out, conv_clk_en_out});
      cmp("mux", {31'h0, i != 0}, {31'h0, comp_mux_allow_out});
    end
    c0 = tcount;
    repeat (5) @(posedge core_clk_in);
    #1;
    cmp("frozen", {24'h0, c0}, {24'h0, tcount});
    bus(1'b1, PRR_ADDR, 8'h00);
    repeat (3) @(posedge core_clk_in);
    #1;
    cmp("resumed", 32'h1, {31'h0, tcount > c0 && tcount < c0 + 8'h08});
    bus(1'b1, PRR_ADDR, 8'hff);
    rd(PRR_ADDR, 32'h0f);
    bus(1'b1, PRR_ADDR, 8'h00);
    bus(1'b1, SMC_ADDR, 8'hff);
    rd(SMC_ADDR, 32'h0f);
    foreach (modes[m]) begin
      bus(1'b1, SMC_ADDR, {4'h0, modes[m], 1'b1});
      pulse_sleep();
      wait_for(2, 1'b1);
      sleep_instr_in <= 1'b0;
      cmp("mode", {29'h0, modes[m]}, {29'h0, sleep_mode_out});
      @(posedge core_clk_in);
      wake_in <= 1'b1;
      wait_for(3, 1'b1);
      wake_in <= 1'b0;
      cmp("wake", 32'h1, {31'h0, n < 7});
      bus(1'b1, SMC_ADDR, 8'h00);
    end
    pulse_sleep();
    watch(2, 6);
    sleep_instr_in <= 1'b0;
    cmp("unarmed", 32'h0, hi);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, RST_CTL_ADDR, 8'h02 << i);
      repeat (2) @(posedge core_clk_in);
      #1;
      cmp("bandgap", {31'h0, i < 2}, {31'h0, bandgap_en_out});
    end
    @(posedge core_clk_in);
    brownout_level_fuse_in <= 2'h1;
    bod_low_in <= 1'b1;
    watch(0, 20);
    cmp("short dip", 32'h0, hi);
    cmp("bandgap", 32'h1, {31'h0, bandgap_en_out});
    watch(0, 100);
    cmp("long dip", 32'h1, {31'h0, hi > 0});
    @(posedge core_clk_in);
    bod_low_in <= 1'b0;
    wait_for(1, 1'b0);
    brownout_level_fuse_in <= 2'h3;
    wdt_expire_in <= 1'b1;
    @(posedge core_clk_in);
    wdt_expire_in <= 1'b0;
    watch(4, 8);
    cmp("disabled watchdog", 32'h0, hi);
    @(posedge core_clk_in);
    wdt_enable_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    wdt_expire_in <= 1'b1;
    @(posedge core_clk_in);
    wdt_expire_in <= 1'b0;
    watch(4, 10);
    cmp("watchdog pulse", 32'h1, hi);
    wait_for(1, 1'b0);
    wdt_enable_in <= 1'b0;
    for (int f = 0; f < 3; f++) begin
      bus(1'b1, SMC_ADDR, 8'h0c);
      @(posedge core_clk_in);
      startup_time_fuse_in <= {1'b0, f == 1};
      tout = (f == 1) ? 20 : 8;
      if (f == 2) por_low_in <= 1'b1;
      else ext_rst_n_in <= 1'b0;
      watch(0, 6);
      cmp("port reset", 32'h1, {31'h0, hi > 1});
      @(posedge core_clk_in);
      por_low_in <= 1'b0;
      ext_rst_n_in <= 1'b1;
      wait_for(0, 1'b0);
      wait_for(1, 1'b0);
      cmp("stretch", 32'h1, {31'h0, n >= tout && n <= tout + 2});
      rd(SMC_ADDR, 32'h0);
    end
    complete_run();
  end
endmodule
